// ---- sirqs_top.sv ----
/*
 Serial interrupt slave: filters interrupt pins on the system clock and
 sends their levels in the serial frames of the link clock.
 Assumes an external pull-up on the shared line and a host that makes the
 start pulse width and the stop frames.
*/
`timescale 1ns/1ps
module sirqs_top
   import sirqs_pkg::*;
(
   // System clock domain
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [15:1] irq_pin,
   // Link clock domain
   input wire logic link_clock,
   input wire logic bus_reset_drive_n,
   input wire logic serial_interrupt_pin_in,
   output logic serial_interrupt_pin_out,
   output logic serial_interrupt_pin_oe_n,
   // Status on the link clock
   output logic quiet_mode,
   output logic bus_active
);

   // ----------------------------------------------------------------
   // Pin filtering on the system clock
   // ----------------------------------------------------------------
   logic [15:1] p1_r, p2_r, p3_r, flt_r;
   logic [15:1] p1_nxt, p2_nxt, p3_nxt, flt_nxt;

   // A bit moves only once the second and third stages agree.
   always_comb
   begin
      p1_nxt = irq_pin;
      p2_nxt = p1_r;
      p3_nxt = p2_r;
      flt_nxt = flt_r;
      for (int i = 1; i <= NUM_IRQ; i++)
      begin
         if (p2_r[i] == p3_r[i])
         begin
            flt_nxt[i] = p3_r[i];
         end
      end
   end

   // Registers only.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         p1_r <= LVL_RST;
         p2_r <= LVL_RST;
         p3_r <= LVL_RST;
         flt_r <= LVL_RST;
      end
      else
      begin
         p1_r <= p1_nxt;
         p2_r <= p2_nxt;
         p3_r <= p3_nxt;
         flt_r <= flt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Level crossing into the link clock
   // ----------------------------------------------------------------
   // Three stages per bit with the same agreement test as on the pins.
   // Each bit is an independent level, so a change is late by a few link
   // clocks but never lost; the serial frames tolerate that latency.
   logic [15:1] s1_r, s2_r, s3_r, lvl_r;
   logic [15:1] s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

   // Only the last two stages are compared; the first may be metastable.
   always_comb
   begin
      s1_nxt = flt_r;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      lvl_nxt = lvl_r;
      for (int i = 1; i <= NUM_IRQ; i++)
      begin
         if (s2_r[i] == s3_r[i])
         begin
            lvl_nxt[i] = s3_r[i];
         end
      end
   end

   // Registers only; bus reset returns every stage to the idle level.
   always_ff @(posedge link_clock)
   begin
      if (!bus_reset_drive_n)
      begin
         s1_r <= LVL_RST;
         s2_r <= LVL_RST;
         s3_r <= LVL_RST;
         lvl_r <= LVL_RST;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Serial frame engine on the link clock
   // ----------------------------------------------------------------
   // Frame N carries IRQ N-1, so frame 3 is IRQ2 and frame 14 is IRQ13.
   function automatic logic slot_ok(input logic [4:0] fr);
      slot_ok = (fr >= FR_FIRST_IRQ) && (fr <= FR_LAST_IRQ);
   endfunction : slot_ok

   sirqs_st_e st_r, st_nxt;
   logic [1:0] ph_r, ph_nxt;
   logic [4:0] fr_r, fr_nxt;
   logic [2:0] low_r, low_nxt;
   logic quiet_r, quiet_nxt;
   logic drove_r, drove_nxt;
   logic [15:1] sent_r, sent_nxt;
   sirqs_drv_s drv_r, drv_nxt;
   logic line;
   logic pending;
   logic [3:0] idx;

   assign line = serial_interrupt_pin_in;
   assign idx = fr_r[3:0] - 4'h1;
   assign pending = |(lvl_r ^ sent_r);

   // Next state. The pin is read in the same clock, which is the bus clock.
   always_comb
   begin
      st_nxt = st_r;
      ph_nxt = ph_r;
      fr_nxt = fr_r;
      low_nxt = low_r;
      quiet_nxt = quiet_r;
      sent_nxt = sent_r;
      drv_nxt = DRV_RELEASE;
      drove_nxt = 1'b0;
      case (st_r)
         ST_IDLE:
         begin
            if (!line)
            begin
               st_nxt = ST_START;
            end
            else if (quiet_r && pending)
            begin
               drv_nxt = DRV_LOW;
               st_nxt = ST_START;
            end
         end
         ST_START:
         begin
            // The host stretches the pulse and drives it back high.
            if (line)
            begin
               st_nxt = ST_DATA;
               ph_nxt = PH_AT_RISE;
               fr_nxt = FR_AT_RISE;
               low_nxt = 3'h0;
            end
         end
         ST_DATA:
         begin
            ph_nxt = (ph_r == PH_SAMPLE) ? PH_RECOVERY : ph_r + 2'h1;
            if (ph_r == PH_RECOVERY && fr_r != FR_MAX)
            begin
               fr_nxt = fr_r + 5'h01;
            end
            if (ph_r == PH_SAMPLE && slot_ok(fr_r))
            begin
               sent_nxt[idx] = lvl_r[idx];
               if (!lvl_r[idx])
               begin
                  drv_nxt = DRV_LOW;
                  drove_nxt = 1'b1;
               end
            end
            if (ph_r == PH_RECOVERY && drove_r)
            begin
               drv_nxt = DRV_HIGH;
            end
            // Only the host holds the line low two clocks or more.
            if (!line)
            begin
               low_nxt = (low_r == LOW_MAX) ? low_r : low_r + 3'h1;
            end
            else
            begin
               if (low_r >= STOP_MIN_LOW)
               begin
                  quiet_nxt = (low_r == STOP_QUIET_LOW);
                  st_nxt = ST_GAP;
               end
               low_nxt = 3'h0;
            end
         end
         ST_GAP:
         begin
            // One clock of hold-off keeps our own start off the first clock.
            st_nxt = ST_IDLE;
         end
         default:
         begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Registers only; reset leaves the bus continuous and released.
   always_ff @(posedge link_clock)
   begin
      if (!bus_reset_drive_n)
      begin
         st_r <= ST_IDLE;
         ph_r <= PH_RECOVERY;
         fr_r <= FR_AT_RISE;
         low_r <= 3'h0;
         quiet_r <= QUIET_RST;
         drove_r <= 1'b0;
         sent_r <= LVL_RST;
         drv_r <= DRV_RELEASE;
      end
      else
      begin
         st_r <= st_nxt;
         ph_r <= ph_nxt;
         fr_r <= fr_nxt;
         low_r <= low_nxt;
         quiet_r <= quiet_nxt;
         drove_r <= drove_nxt;
         sent_r <= sent_nxt;
         drv_r <= drv_nxt;
      end
   end

   // Pin and status outputs.
   assign serial_interrupt_pin_out = drv_r.out;
   assign serial_interrupt_pin_oe_n = drv_r.oe_n;
   assign quiet_mode = quiet_r;
   assign bus_active = (st_r == ST_START) || (st_r == ST_DATA);

   // ----------------------------------------------------------------
   // Checks on the link clock
   // ----------------------------------------------------------------
   a_start_one_low: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (st_r == ST_IDLE && line && quiet_r && pending)
      |=> (drv_r == DRV_LOW) ##1 (drv_r == DRV_RELEASE))
      else $error("own start pulse is not one low clock");

   a_start_no_high: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (drv_r == DRV_LOW && $past(st_r) == ST_IDLE) |=> drv_r.oe_n [*2])
      else $error("line driven after own start clock");

   a_idle_only_start: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (drv_r == DRV_LOW) |-> ($past(st_r) == ST_IDLE
      || ($past(st_r) == ST_DATA && $past(ph_r) == PH_SAMPLE)))
      else $error("low driven outside idle and sample");

   a_cont_passive: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (st_r == ST_IDLE && !quiet_r) |=> drv_r.oe_n)
      else $error("start attempted in continuous mode");

   a_mode_at_stop: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (quiet_r != $past(quiet_r)) |-> ($past(st_r) == ST_DATA && st_r == ST_GAP))
      else $error("mode changed outside a stop frame");

   a_stop_width: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (st_r == ST_DATA && line && low_r >= STOP_MIN_LOW)
      |=> (quiet_r == ($past(low_r) == STOP_QUIET_LOW)))
      else $error("stop width decoded to wrong mode");

   a_irq1_slot: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      ($rose(st_r == ST_DATA) ##4 (st_r == ST_DATA && !lvl_r[1]))
      |=> (drv_r == DRV_LOW) ##1 (drv_r == DRV_HIGH) ##1 drv_r.oe_n)
      else $error("IRQ1 slot not at clock five");

   a_recover_high: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (drv_r == DRV_LOW && $past(st_r) == ST_DATA && $past(ph_r) == PH_SAMPLE)
      |=> (drv_r == DRV_HIGH) ##1 drv_r.oe_n)
      else $error("no recovery high after sample low");

   a_stop_holdoff: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (st_r == ST_GAP) |=> drv_r.oe_n ##1 (st_r != ST_GAP))
      else $error("start inside stop hold-off");

   a_turn_release: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (st_r == ST_DATA && ph_r == PH_TURN) |=> drv_r.oe_n)
      else $error("line not released in turn-around");

   a_high_released: assert property (@(posedge link_clock)
      disable iff (!bus_reset_drive_n)
      (st_r == ST_DATA && ph_r == PH_SAMPLE && slot_ok(fr_r) && lvl_r[idx])
      |=> drv_r.oe_n)
      else $error("high level driven in its sample slot");

endmodule : sirqs_top

// ---- sirqs_pkg.sv ----
/*
 Constants, types and state encoding for the serial interrupt slave.
 Assumes one user of the package: the slave top module in this folder.
*/
// How it works
// - In quiet mode on an idle bus, pull the line low exactly one clock.
// - After that single low clock release the line; never drive it high.
// - Never begin a start frame while a cycle is active.
// - In quiet mode, begin a start frame when an interrupt level changed.
// - In continuous mode only the host begins a start frame; slave stays passive.
// - Mode changes only at a stop frame or a bus reset and holds from then on.
// - After reset the bus is continuous, so the host starts the first cycle.
// - Measure the low width of every stop pulse to choose the next mode.
// - Count data frames from the start pulse rising edge, three clocks each.
// - In an owned sample phase drive low only if the level was low.
// - Drive high in recovery exactly when low was driven in the sample phase.
// - Release the line in every turn-around phase.
// - Send low levels in every cycle, whoever began the start frame.
// - Sample clock of frame N falls 3N-1 clocks after the start rising edge.
// - Frame 3 carries IRQ2 and frame 14 carries IRQ13.
// - Stop low of two clocks selects quiet mode, three selects continuous.
// - No start before the second clock after the stop rising edge.
// - Tolerate idle clocks in the stop frame and a delayed next start.
// - Drive and sample the line only on the rising edge of the bus clock.
// - Keep the line released in bus reset; leave reset in continuous idle.
package sirqs_pkg;

   // ----------------------------------------------------------------
   // Frame and phase counting
   // ----------------------------------------------------------------
   localparam int NUM_IRQ = 15;
   localparam logic [1:0] PH_RECOVERY = 2'h0;
   localparam logic [1:0] PH_TURN = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_AT_RISE = 2'h1;
   localparam logic [4:0] FR_AT_RISE = 5'h01;
   localparam logic [4:0] FR_FIRST_IRQ = 5'h02;
   localparam logic [4:0] FR_LAST_IRQ = 5'h10;
   localparam logic [4:0] FR_MAX = 5'h1F;

   // ----------------------------------------------------------------
   // Stop frame widths and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] STOP_MIN_LOW = 3'h2;
   localparam logic [2:0] STOP_QUIET_LOW = 3'h2;
   localparam logic [2:0] LOW_MAX = 3'h7;
   localparam logic QUIET_RST = 1'b0;
   localparam logic [15:1] LVL_RST = 15'h7FFF;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_GAP} sirqs_st_e;

   typedef struct packed {
      logic out;
      logic oe_n;
   } sirqs_drv_s;

   localparam sirqs_drv_s DRV_RELEASE = '{out: 1'b1, oe_n: 1'b1};
   localparam sirqs_drv_s DRV_LOW = '{out: 1'b0, oe_n: 1'b0};
   localparam sirqs_drv_s DRV_HIGH = '{out: 1'b1, oe_n: 1'b0};

endpackage : sirqs_pkg

// ---- sirqs_host.sv ----
/*
 Host model for the serial interrupt bus: start pulse takeover, frame
 sampling and stop frames.
 Assumes the bench resolves the shared line with a pull-up.
*/
`timescale 1ns/1ps
module sirqs_host
(
   // Link side
   input wire logic link_clock,
   input wire logic line,
   // Host drive
   output logic drv_en,
   output logic drv_val
);
   // ----------------------------------------------------------------
   // Drive helpers
   // ----------------------------------------------------------------
   // Released at power up and during bus reset.
   initial
   begin
      drv_en = 1'b0;
      drv_val = 1'b1;
   end

   // Changes just after an edge and holds for one whole link clock.
   task automatic drive(input logic en, input logic v);
      @(posedge link_clock);
      #1;
      drv_en = en;
      drv_val = v;
   endtask : drive

   // One cycle; the level seen mid-clock in each sample slot is returned.
   // A missed device start leaves the slots unknown, so the bench notices.
   task automatic cycle(input int width, input int stop_w, input int idle, input bit dev,
      output logic [16:1] s);
      int k;
      s = 'x;
      k = 0;
      @(posedge link_clock);
      #1;
      while (dev && line !== 1'b0 && k < 300)
      begin
         @(posedge link_clock);
         #1;
         k++;
      end
      if (k == 300)
         return;
      repeat (width - (dev ? 1 : 0)) drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
      drive(1'b0, 1'b1);
      for (int n = 1; n <= 16; n++)
      begin
         repeat (n == 1 ? 2 : 3) @(posedge link_clock);
         @(negedge link_clock);
         s[n] = line;
      end
      repeat (2 + idle) @(posedge link_clock);
      repeat (stop_w) drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
      drive(1'b0, 1'b1);
   endtask : cycle
endmodule : sirqs_host

// ---- sirqs_top_test.sv ----
/*
 Self-checking bench for the serial interrupt slave with a host model.
 Assumes a pull-up on the shared line and unrelated system and link clocks.
*/
`timescale 1ns/1ps
module sirqs_top_test;
   logic clock;
   logic rst_n;
   logic link_clock;
   logic bus_reset_drive_n;
   logic [15:1] irq_pin;
   logic pin_out;
   logic pin_oe_n;
   logic quiet_mode;
   logic bus_active;
   logic line;
   logic h_en;
   logic h_val;
   int n_errors = 0;
   int tests_run = 0;
   int dev_drv = 0;
   int act_cnt = 0;
   int seed = 32'hDDCBCC46;

   // ----------------------------------------------------------------
   // Clocks, line and instances
   // ----------------------------------------------------------------
   // The system clock toggles every half period.
   always #5 clock = ~clock;

   // The link clock starts off phase so the domains never line up.
   initial
   begin
      link_clock = 1'b0;
      #1.3;
      forever #3 link_clock = ~link_clock;
   end

   // Pull-up wins only when nobody drives.
   assign line = !pin_oe_n ? pin_out : (h_en ? h_val : 1'b1);

   // Counts link clocks in which the slave drives the line, and those in
   // which it reports the bus as active.
   always @(posedge link_clock)
   begin
      if (pin_oe_n === 1'b0)
         dev_drv++;
      if (bus_active === 1'b1)
         act_cnt++;
   end

   sirqs_top dut (
      .clock(clock), .rst_n(rst_n), .irq_pin(irq_pin),
      .link_clock(link_clock), .bus_reset_drive_n(bus_reset_drive_n),
      .serial_interrupt_pin_in(line), .serial_interrupt_pin_out(pin_out),
      .serial_interrupt_pin_oe_n(pin_oe_n), .quiet_mode(quiet_mode),
      .bus_active(bus_active));

   sirqs_host host (.link_clock(link_clock), .line(line), .drv_en(h_en),
      .drv_val(h_val));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   // A hang cuts the run short well past the expected few microseconds.
   initial
   begin
      #200000;
      n_errors++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   // Each pass flips random levels, then runs one cycle in the mode that
   // the previous stop frame or bus reset chose; the expected slots follow the levels.
   initial
   begin
      logic [16:1] s;
      logic [16:1] e;
      logic [15:1] m;
      int w;
      int sw;
      int cnt;
      int idl;
      int ac;
      bit quiet;
      clock = 1'b0;
      rst_n = 1'b0;
      bus_reset_drive_n = 1'b0;
      irq_pin = 15'h7FFF;
      quiet = 1'b0;
      repeat (10) @(posedge clock);
      #1 rst_n = 1'b1;
      @(posedge link_clock);
      #1 bus_reset_drive_n = 1'b1;
      check("oe_n after reset", {31'h0, pin_oe_n}, 32'h1);
      check("quiet_mode after reset", {31'h0, quiet_mode}, 32'h0);
      for (int i = 0; i < 12; i++)
      begin
         w = 4 + ($unsigned($random(seed)) % 5);
         sw = ($random(seed) & 1) ? 2 : 3;
         idl = $unsigned($random(seed)) % 3;
         // One forced quiet stop, so that the bus reset below must clear it.
         if (i == 6)
            sw = 2;
         m = 15'($random(seed));
         if (m == 15'h0)
            m = 15'h1;
         @(posedge clock);
         #1 irq_pin = irq_pin ^ m;
         if (!quiet)
         begin
            cnt = dev_drv;
            repeat (40) @(posedge link_clock);
            check("drive in continuous idle", dev_drv - cnt, 32'h0);
         end
         ac = act_cnt;
         host.cycle(w, sw, idl, quiet, s);
         e = {irq_pin, 1'b1};
         check("slots", {16'h0, s}, {16'h0, e});
         @(posedge link_clock);
         #1;
         check("quiet_mode", {31'h0, quiet_mode}, sw == 2);
         check("bus_active", {31'h0, bus_active}, 32'h0);
         // Active from the start pulse to the stop rise; an own start adds one.
         check("active clocks", act_cnt - ac, w + 51 + sw + idl + (quiet ? 1 : 0));
         quiet = (sw == 2);
         if (i == 6)
         begin
            bus_reset_drive_n = 1'b0;
            repeat (2) @(posedge link_clock);
            #1;
            check("oe_n in bus reset", {31'h0, pin_oe_n}, 32'h1);
            check("quiet_mode in bus reset", {31'h0, quiet_mode}, 32'h0);
            bus_reset_drive_n = 1'b1;
            repeat (2) @(posedge link_clock);
            #1;
            check("quiet_mode after bus reset", {31'h0, quiet_mode}, 32'h0);
            check("bus_active after bus reset", {31'h0, bus_active}, 32'h0);
            quiet = 1'b0;
         end
      end
      summarize();
   end
endmodule : sirqs_top_test
